/* sbg_top.sv */
/*
  data register and baud rate generation for an asynchronous serial master.
  assumes registers reached by plain strobe port, read data one cycle later;
  the shift registers live outside and meet this block by valid/ready for transmit, valid only for receive.
*/
// Added by the designer: the strobed register port and the placing of the registers.
`timescale 1ns/10ps
// Notes on behaviour
// - data read returns last received byte; write loads transmit byte.
// - separate transmit and receive holding registers behind one address.
// - transmit holding byte goes to the outgoing shifter.
// - receive holding register captures incoming shifter byte for reads.
// - coarse select divides clock by 1, 3, 4 or 13.
// - transmit select divides further by two to the code.
// - receive select divides by two to the code, independently.
// - non-zero transmit fine value multiplies the transmit factor.
// - non-zero receive fine value multiplies the receive factor.
// - receive fine divides the post-sixteen clock by 1 to 255.
// - transmit fine divides the post-sixteen clock by 1 to 255.
// - rate and fine registers reset to zero.
// - low-power bit stops prescalers and outputs after current byte.
module sbg_top
  import sbg_pkg::*;
#(
  parameter int DATA_W = 8,
  parameter int FIFO_DEPTH = SBG_FIFO_DEPTH
) (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic ce_in,
  input wire logic [2:0] addr_in,
  input wire logic [7:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  output logic [7:0] rdata_out,
  output logic tx_valid_out,
  output logic [DATA_W-1:0] tx_data_out,
  input wire logic tx_ready_in,
  input wire logic tx_busy_in,
  input wire logic rx_valid_in,
  input wire logic [DATA_W-1:0] rx_data_in,
  input wire logic rx_busy_in,
  output logic tx_tick_out,
  output logic rx_tick_out,
  output logic tx_full_out
);
  logic [7:0] rate_select_reg;
  logic [7:0] rx_fine_divisor_reg;
  logic [7:0] tx_fine_divisor_reg;
  logic serial_low_power_off_reg;
  logic halted_reg;
  logic [DATA_W-1:0] rx_holding_reg;
  logic [7:0] rdata_reg;
  logic tx_valid_reg;
  logic [DATA_W-1:0] tx_holding_reg;
  logic tx_tick_reg;
  logic rx_tick_reg;
  logic tx_full_reg;
  logic tx_tick_w;
  logic rx_tick_w;

  sbg_bus_if #(.WIDTH(DATA_W)) fin ();
  sbg_bus_if #(.WIDTH(DATA_W)) fout ();

  // register decode
  wire wr_data = wr_in && addr_in == SBG_OFF_DATA;
  wire wr_rate = wr_in && addr_in == SBG_OFF_RATE;
  wire wr_rxf = wr_in && addr_in == SBG_OFF_RXFINE;
  wire wr_txf = wr_in && addr_in == SBG_OFF_TXFINE;
  wire wr_ctrl = wr_in && addr_in == SBG_OFF_CTRL;

  assign fin.valid = ce_in && wr_data;
  assign fin.data = DATA_W'(wdata_in);
  assign fout.ready = !tx_valid_reg || tx_ready_in;

  sbg_fifo #(.WIDTH(DATA_W), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clk_in(clk_in),
    .rst_n_in(rst_n_in),
    .ce_in(ce_in && !halted_reg),
    .wr(fin.snk),
    .rd(fout.src)
  );

  wire idle_now = !tx_busy_in && !rx_busy_in && !tx_valid_reg;
  wire halted_next = serial_low_power_off_reg && (halted_reg || idle_now);

  wire [1:0] coarse_prescale_sel = rate_select_reg[SBG_COARSE_MSB:SBG_COARSE_LSB];
  wire [2:0] tx_rate_divisor_sel = rate_select_reg[SBG_TXSEL_MSB:SBG_TXSEL_LSB];
  wire [2:0] rx_rate_divisor_sel = rate_select_reg[SBG_RXSEL_MSB:SBG_RXSEL_LSB];
  wire [3:0] coarse_div_factor = (coarse_prescale_sel == 2'h0) ? SBG_PRE_1 :
                                 (coarse_prescale_sel == 2'h1) ? SBG_PRE_3 :
                                 (coarse_prescale_sel == 2'h2) ? SBG_PRE_4 : SBG_PRE_13;

  sbg_divider u_txdiv (
    .clk_in(clk_in),
    .rst_n_in(rst_n_in),
    .run_in(ce_in && !halted_reg),
    .coarse_in(coarse_div_factor),
    .pow_sel_in(tx_rate_divisor_sel),
    .fine_in(tx_fine_divisor_reg),
    .tick_out(tx_tick_w)
  );

  sbg_divider u_rxdiv (
    .clk_in(clk_in),
    .rst_n_in(rst_n_in),
    .run_in(ce_in && !halted_reg),
    .coarse_in(coarse_div_factor),
    .pow_sel_in(rx_rate_divisor_sel),
    .fine_in(rx_fine_divisor_reg),
    .tick_out(rx_tick_w)
  );

  // read mux
  wire [7:0] rd_mux = (addr_in == SBG_OFF_DATA) ? 8'(rx_holding_reg) :
                      (addr_in == SBG_OFF_RATE) ? rate_select_reg :
                      (addr_in == SBG_OFF_RXFINE) ? rx_fine_divisor_reg :
                      (addr_in == SBG_OFF_TXFINE) ? tx_fine_divisor_reg :
                      (addr_in == SBG_OFF_CTRL) ? {7'h00, serial_low_power_off_reg} :
                      (addr_in == SBG_OFF_STAT) ? {5'h00, halted_reg, !fin.ready, fout.valid} :
                      8'h00;

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rate_select_reg <= SBG_RATE_RST;
      rx_fine_divisor_reg <= SBG_FINE_RST;
      tx_fine_divisor_reg <= SBG_FINE_RST;
      serial_low_power_off_reg <= 1'b0;
      halted_reg <= 1'b0;
    end else if (ce_in) begin
      if (wr_rate) rate_select_reg <= wdata_in;
      if (wr_rxf) rx_fine_divisor_reg <= wdata_in;
      if (wr_txf) tx_fine_divisor_reg <= wdata_in;
      if (wr_ctrl) serial_low_power_off_reg <= wdata_in[SBG_CTRL_OFF_BIT];
      halted_reg <= halted_next;
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rx_holding_reg <= '0;
    end else if (ce_in && rx_valid_in && !halted_reg) begin
      rx_holding_reg <= rx_data_in;
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      tx_valid_reg <= 1'b0;
      tx_holding_reg <= '0;
    end else if (ce_in && !halted_reg && fout.ready) begin
      tx_valid_reg <= fout.valid;
      if (fout.valid) tx_holding_reg <= fout.data;
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rdata_reg <= 8'h00;
      tx_tick_reg <= 1'b0;
      rx_tick_reg <= 1'b0;
      tx_full_reg <= 1'b0;
    end else if (ce_in) begin
      rdata_reg <= rd_in ? rd_mux : 8'h00;
      tx_tick_reg <= tx_tick_w && !halted_reg;
      rx_tick_reg <= rx_tick_w && !halted_reg;
      tx_full_reg <= !fin.ready;
    end
  end

  assign rdata_out = rdata_reg;
  assign tx_valid_out = tx_valid_reg;
  assign tx_data_out = tx_holding_reg;
  assign tx_tick_out = tx_tick_reg;
  assign rx_tick_out = rx_tick_reg;
  assign tx_full_out = tx_full_reg;

  // period watch, restarted by rate or fine writes or stops
  logic [22:0] tx_gap_reg;
  logic [22:0] rx_gap_reg;
  logic tx_gap_ok_reg;
  logic rx_gap_ok_reg;
  wire gap_restart = wr_rate || !ce_in || halted_reg;
  wire [22:0] tx_fine_mul = (tx_fine_divisor_reg == 8'h00) ? 23'h000001 :
                            23'(tx_fine_divisor_reg);
  wire [22:0] rx_fine_mul = (rx_fine_divisor_reg == 8'h00) ? 23'h000001 :
                            23'(rx_fine_divisor_reg);
  wire [22:0] tx_expect = 23'(coarse_div_factor) * (23'h000001 << tx_rate_divisor_sel)
                          * tx_fine_mul * 23'(SBG_OVERSAMPLE);
  wire [22:0] rx_expect = 23'(coarse_div_factor) * (23'h000001 << rx_rate_divisor_sel)
                          * rx_fine_mul * 23'(SBG_OVERSAMPLE);

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      tx_gap_reg <= '0;
      tx_gap_ok_reg <= 1'b0;
    end else if (gap_restart || wr_txf) begin
      tx_gap_reg <= '0;
      tx_gap_ok_reg <= 1'b0;
    end else if (tx_tick_w) begin
      tx_gap_reg <= '0;
      tx_gap_ok_reg <= 1'b1;
    end else begin
      tx_gap_reg <= tx_gap_reg + 23'h000001;
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rx_gap_reg <= '0;
      rx_gap_ok_reg <= 1'b0;
    end else if (gap_restart || wr_rxf) begin
      rx_gap_reg <= '0;
      rx_gap_ok_reg <= 1'b0;
    end else if (rx_tick_w) begin
      rx_gap_reg <= '0;
      rx_gap_ok_reg <= 1'b1;
    end else begin
      rx_gap_reg <= rx_gap_reg + 23'h000001;
    end
  end

  // checks
  property p_rx_read;
    @(posedge clk_in) disable iff (!rst_n_in)
    ce_in && rd_in && addr_in == SBG_OFF_DATA |=> rdata_out == 8'($past(rx_holding_reg));
  endproperty
  a_rx_read: assert property (p_rx_read) else $error("data read wrong");

  property p_write_keeps_rx;
    @(posedge clk_in) disable iff (!rst_n_in)
    ce_in && wr_data && !rx_valid_in |=> $stable(rx_holding_reg);
  endproperty
  a_write_keeps_rx: assert property (p_write_keeps_rx) else $error("write altered rx");

  property p_tx_path;
    @(posedge clk_in) disable iff (!rst_n_in)
    ce_in && !halted_reg && fout.valid && fout.ready |=> tx_valid_out && tx_data_out == $past(fout.data);
  endproperty
  a_tx_path: assert property (p_tx_path) else $error("tx byte not passed");

  property p_rx_cap;
    @(posedge clk_in) disable iff (!rst_n_in)
    ce_in && rx_valid_in && !halted_reg |=> rx_holding_reg == $past(rx_data_in);
  endproperty
  a_rx_cap: assert property (p_rx_cap) else $error("rx not captured");

  property p_coarse;
    @(posedge clk_in) disable iff (!rst_n_in)
    coarse_prescale_sel == 2'h3 |-> coarse_div_factor == 4'hd;
  endproperty
  a_coarse: assert property (p_coarse) else $error("coarse factor wrong");

  property p_tx_rate;
    @(posedge clk_in) disable iff (!rst_n_in)
    tx_gap_ok_reg && tx_tick_w |-> tx_gap_reg == tx_expect - 23'h000001;
  endproperty
  a_tx_rate: assert property (p_tx_rate) else $error("tx rate wrong");

  property p_rx_rate;
    @(posedge clk_in) disable iff (!rst_n_in)
    rx_gap_ok_reg && rx_tick_w |-> rx_gap_reg == rx_expect - 23'h000001;
  endproperty
  a_rx_rate: assert property (p_rx_rate) else $error("rx rate wrong");

  property p_reset_zero;
    @(posedge clk_in) $rose(rst_n_in) |-> rate_select_reg == 8'h00 && tx_fine_divisor_reg == 8'h00;
  endproperty
  a_reset_zero: assert property (p_reset_zero) else $error("reset values wrong");

  property p_halt_quiet;
    @(posedge clk_in) disable iff (!rst_n_in)
    ce_in && halted_reg |=> !tx_tick_out && !rx_tick_out;
  endproperty
  a_halt_quiet: assert property (p_halt_quiet) else $error("ticks while stopped");

  property p_halt_between;
    @(posedge clk_in) disable iff (!rst_n_in)
    ce_in && !halted_reg && (tx_busy_in || rx_busy_in) |=> !halted_reg;
  endproperty
  a_halt_between: assert property (p_halt_between) else $error("stopped mid byte");

  c_write_data: cover property (@(posedge clk_in) wr_data);
  c_fifo_full: cover property (@(posedge clk_in) !fin.ready);
  c_halted: cover property (@(posedge clk_in) halted_reg);
  c_fine_tick: cover property (@(posedge clk_in) tx_fine_divisor_reg != 8'h00 && tx_tick_w);
endmodule

/* sbg_pkg.sv */
/*
  package for the serial baud generator and data register block:
  register indices, field positions, reset values and divider constants.
  assumes nothing of its surroundings.
*/
package sbg_pkg;
  localparam logic [2:0] SBG_OFF_DATA = 3'h0;
  localparam logic [2:0] SBG_OFF_RATE = 3'h1;
  localparam logic [2:0] SBG_OFF_RXFINE = 3'h2;
  localparam logic [2:0] SBG_OFF_TXFINE = 3'h3;
  localparam logic [2:0] SBG_OFF_CTRL = 3'h4;
  localparam logic [2:0] SBG_OFF_STAT = 3'h5;
  localparam int SBG_COARSE_MSB = 7;
  localparam int SBG_COARSE_LSB = 6;
  localparam int SBG_TXSEL_MSB = 5;
  localparam int SBG_TXSEL_LSB = 3;
  localparam int SBG_RXSEL_MSB = 2;
  localparam int SBG_RXSEL_LSB = 0;
  localparam int SBG_CTRL_OFF_BIT = 0;
  localparam logic [7:0] SBG_RATE_RST = 8'h00;
  localparam logic [7:0] SBG_FINE_RST = 8'h00;
  localparam logic [3:0] SBG_PRE_1 = 4'h1;
  localparam logic [3:0] SBG_PRE_3 = 4'h3;
  localparam logic [3:0] SBG_PRE_4 = 4'h4;
  localparam logic [3:0] SBG_PRE_13 = 4'hd;
  localparam logic [4:0] SBG_OVERSAMPLE = 5'h10;
  localparam int SBG_FIFO_DEPTH = 8;
  localparam real SBG_CLK_NS = 10.0;
  localparam int SBG_CLK_CYCLE = int'(SBG_CLK_NS / SBG_CLK_NS);
endpackage

/* sbg_bus_if.sv */
/*
  interface carrying one byte stream with valid/ready between
  the block's own modules. assumes a single clock domain.
*/
`timescale 1ns/10ps
interface sbg_bus_if #(parameter int WIDTH = 8);
  logic valid;
  logic ready;
  logic [WIDTH-1:0] data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface

/* sbg_fifo.sv */
/*
  small flip-flop fifo, parameter width and depth, valid/ready on both sides.
  assumes one clock, asynchronous active-low reset.
*/
`timescale 1ns/10ps
module sbg_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic ce_in,
  sbg_bus_if.snk wr,
  sbg_bus_if.src rd
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [AW-1:0] wp_reg;
  logic [AW-1:0] rp_reg;
  logic [AW:0] cnt_reg;
  wire do_wr = ce_in && wr.valid && wr.ready;
  wire do_rd = ce_in && rd.valid && rd.ready;
  assign wr.ready = (cnt_reg != (AW+1)'(DEPTH));
  assign rd.valid = (cnt_reg != '0);
  assign rd.data = mem_reg[rp_reg];
  always_ff @(posedge clk_in) begin
    if (do_wr) begin
      mem_reg[wp_reg] <= wr.data;
    end
  end
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      wp_reg <= '0;
      rp_reg <= '0;
      cnt_reg <= '0;
    end else begin
      if (do_wr) wp_reg <= (wp_reg == AW'(DEPTH-1)) ? '0 : wp_reg + 1'b1;
      if (do_rd) rp_reg <= (rp_reg == AW'(DEPTH-1)) ? '0 : rp_reg + 1'b1;
      cnt_reg <= cnt_reg + (AW+1)'(do_wr) - (AW+1)'(do_rd);
    end
  end
  property p_no_overrun;
    @(posedge clk_in) disable iff (!rst_n_in)
    cnt_reg <= (AW+1)'(DEPTH);
  endproperty
  a_no_overrun: assert property (p_no_overrun) else $error("fifo count above depth");
endmodule

/* sbg_divider.sv */
/*
  one rate clock generator: coarse, power-of-two, fine and oversample factors
  multiplied into one counter with a single tick pulse. assumes one clock, enable low holds the count and clears the tick.
*/
`timescale 1ns/10ps
module sbg_divider
  import sbg_pkg::*;
#(
  // holds the largest product, 13 * 128 * 255 * 16
  parameter int CW = 23
) (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic run_in,
  input wire logic [3:0] coarse_in,
  input wire logic [2:0] pow_sel_in,
  input wire logic [7:0] fine_in,
  output logic tick_out
);
  logic [CW-1:0] cnt_reg;
  logic tick_reg;
  wire [7:0] fine_eff = (fine_in == 8'h00) ? 8'h01 : fine_in;
  wire [7:0] pow_factor = 8'h01 << pow_sel_in;
  wire [CW-1:0] total = CW'(coarse_in) * CW'(pow_factor) * CW'(fine_eff) * CW'(SBG_OVERSAMPLE);
  wire at_end = (cnt_reg >= total - CW'(1));
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      cnt_reg <= '0;
      tick_reg <= 1'b0;
    end else if (run_in) begin
      cnt_reg <= at_end ? '0 : cnt_reg + CW'(1);
      tick_reg <= at_end;
    end else begin
      tick_reg <= 1'b0;
    end
  end
  assign tick_out = tick_reg;
endmodule

/* sbg_shifter_model.sv */
/*
  far-side shifter model: takes transmit bytes, hands over received bytes.
  assumes the block's single clock and asynchronous active-low reset.
*/
`timescale 1ns/10ps
module sbg_shifter_model (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic stall_in,
  input wire logic rx_go_in,
  input wire logic [7:0] rx_byte_in,
  input wire logic tx_valid_in,
  input wire logic [7:0] tx_data_in,
  output logic tx_ready_out,
  output logic rx_valid_out,
  output logic [7:0] rx_data_out,
  output logic [7:0] got_out,
  output logic [7:0] got_cnt_out
);
  assign tx_ready_out = !stall_in;
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      got_out <= 8'h00;
      got_cnt_out <= 8'h00;
      rx_valid_out <= 1'b0;
      rx_data_out <= 8'hff;
    end else begin
      if (tx_valid_in && tx_ready_out) begin
        got_out <= tx_data_in;
        got_cnt_out <= got_cnt_out + 8'h01;
      end
      rx_valid_out <= rx_go_in;
      rx_data_out <= rx_go_in ? rx_byte_in : ~rx_data_out;
    end
  end
endmodule

/* serial_baud_gen_and_data_reg_bench.sv */
/*
  self-checking bench for sbg_top: register port, rate ticks, data path.
  assumes the shifter model on the far side and a 100 MHz clock.
*/
`timescale 1ns/10ps
module serial_baud_gen_and_data_reg_bench;
  logic clk_in = 1'b0;
  logic rst_n_in = 1'b0;
  logic [2:0] addr = 3'h0;
  logic [7:0] wdata = 8'h00;
  logic wr_s = 1'b0;
  logic rd_s = 1'b0;
  logic stall = 1'b0;
  logic busy = 1'b0;
  logic rx_go = 1'b0;
  logic [7:0] rx_byte = 8'h00;
  logic [7:0] rdata, tx_data, rx_data, got, got_cnt, v;
  logic tx_valid, tx_ready, rx_valid, tx_tick, rx_tick, tx_full;
  int num_errors = 0;
  int compares = 0;
  int cyc = 0;
  int tick_cnt = 0;
  int n, c0;
  int row [11][5] = '{'{8'h00, 0, 0, 16, 16}, '{8'h40, 0, 0, 48, 48},
    '{8'h88, 0, 0, 128, 64}, '{8'hc0, 0, 0, 208, 208}, '{8'h09, 2, 0, 64, 32},
    '{8'h12, 0, 0, 64, 64}, '{8'h2b, 0, 0, 512, 128}, '{8'h1d, 0, 0, 128, 512},
    '{8'h26, 0, 0, 256, 1024}, '{8'h3f, 0, 0, 2048, 2048}, '{8'h00, 3, 255, 48, 4080}};

  sbg_top uut (.clk_in(clk_in), .rst_n_in(rst_n_in), .ce_in(1'b1), .addr_in(addr),
    .wdata_in(wdata), .wr_in(wr_s), .rd_in(rd_s), .rdata_out(rdata),
    .tx_valid_out(tx_valid), .tx_data_out(tx_data), .tx_ready_in(tx_ready),
    .tx_busy_in(busy), .rx_valid_in(rx_valid), .rx_data_in(rx_data),
    .rx_busy_in(busy), .tx_tick_out(tx_tick), .rx_tick_out(rx_tick),
    .tx_full_out(tx_full));
  sbg_shifter_model far (.clk_in(clk_in), .rst_n_in(rst_n_in), .stall_in(stall),
    .rx_go_in(rx_go), .rx_byte_in(rx_byte), .tx_valid_in(tx_valid),
    .tx_data_in(tx_data), .tx_ready_out(tx_ready), .rx_valid_out(rx_valid),
    .rx_data_out(rx_data), .got_out(got), .got_cnt_out(got_cnt));

  initial begin
    forever #5 clk_in = ~clk_in;
  end
  always @(negedge clk_in) begin
    if (tx_tick === 1'b1) tick_cnt++;
    if (rx_tick === 1'b1) tick_cnt++;
  end
  always @(posedge clk_in) begin
    cyc++;
    if (cyc == 90000) begin
      num_errors++;
      test_done();
    end
  end

  task automatic test_done;
    $display("compares %0d mismatches %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      num_errors++;
      $display("wrong value at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk_in);
    addr <= a;
    wdata <= d;
    wr_s <= 1'b1;
    @(posedge clk_in);
    wr_s <= 1'b0;
  endtask
  task automatic rd(input logic [2:0] a, output logic [7:0] d);
    @(posedge clk_in);
    addr <= a;
    rd_s <= 1'b1;
    @(posedge clk_in);
    rd_s <= 1'b0;
    @(negedge clk_in);
    d = rdata;
  endtask
  // cycles between two consecutive ticks, bounded
  task automatic period(input bit rx, output int p);
    int i;
    i = 0;
    while (((rx ? rx_tick : tx_tick) !== 1'b1) && i < 9000) begin
      @(posedge clk_in);
      #1;
      i++;
    end
    p = 0;
    do begin
      @(posedge clk_in);
      #1;
      p++;
    end while (((rx ? rx_tick : tx_tick) !== 1'b1) && p < 9000);
  endtask
  task automatic wait_got(input logic [7:0] cnt);
    for (int k = 0; k < 200 && got_cnt !== cnt; k++) @(negedge clk_in);
  endtask

  initial begin
    repeat (16) @(posedge clk_in);
    rst_n_in <= 1'b1;
    for (int i = 0; i < 11; i++) begin
      wr(3'h1, 8'(row[i][0]));
      wr(3'h3, 8'(row[i][1]));
      wr(3'h2, 8'(row[i][2]));
      rd(3'h1, v);
      chk(v, 16'(row[i][0]));
      period(1'b0, n);
      period(1'b0, n);
      chk(16'(n), 16'(row[i][3]));
      period(1'b1, n);
      period(1'b1, n);
      chk(16'(n), 16'(row[i][4]));
    end
    $display("rate rows done");
    @(posedge clk_in);
    rst_n_in <= 1'b0;
    repeat (2) @(posedge clk_in);
    rst_n_in <= 1'b1;
    for (int a = 1; a < 4; a++) begin
      rd(3'(a), v);
      chk(v, 16'h0000);
    end
    rd(3'h6, v);
    chk(v, 16'h0000);
    $display("reset test done");
    wr(3'h0, 8'ha5);
    wait_got(8'h01);
    chk(got, 16'h00a5);
    @(posedge clk_in);
    rx_byte <= 8'h3c;
    rx_go <= 1'b1;
    @(posedge clk_in);
    rx_go <= 1'b0;
    wr(3'h0, 8'h77);
    rd(3'h0, v);
    chk(v, 16'h003c);
    wait_got(8'h02);
    chk(got, 16'h0077);
    $display("data test done");
    @(posedge clk_in);
    stall <= 1'b1;
    for (int i = 1; i <= 10; i++) wr(3'h0, 8'(i));
    @(negedge clk_in);
    chk(tx_full, 16'h0001);
    rd(3'h5, v);
    chk(v[1], 16'h0001);
    @(posedge clk_in);
    stall <= 1'b0;
    wait_got(8'h0b);
    repeat (20) @(posedge clk_in);
    chk(got_cnt, 16'h000b);
    chk(got, 16'h0009);
    $display("fifo test done");
    @(posedge clk_in);
    busy <= 1'b1;
    wr(3'h4, 8'h01);
    c0 = tick_cnt;
    repeat (40) @(posedge clk_in);
    chk(16'(tick_cnt > c0), 16'h0001);
    rd(3'h5, v);
    chk(v[2], 16'h0000);
    @(posedge clk_in);
    busy <= 1'b0;
    repeat (20) @(posedge clk_in);
    c0 = tick_cnt;
    repeat (500) @(posedge clk_in);
    chk(16'(tick_cnt - c0), 16'h0000);
    rd(3'h5, v);
    chk(v[2], 16'h0001);
    wr(3'h4, 8'h00);
    c0 = tick_cnt;
    repeat (100) @(posedge clk_in);
    chk(16'(tick_cnt > c0), 16'h0001);
    $display("low power test done");
    test_done();
  end
endmodule
